// ### hdl/gnss_pkg.sv
// Purpose: shared constants and types of the receiver host serial port
// Assumes: one 10 MHz clock
// Notes:   serial rates are held as an index; divisors come from rate_div
package gnss_pkg;
   localparam int CLK_HZ          = 10_000_000;
   localparam int SECOND_MS       = 1000;
   localparam int SEC_CYCLES      = CLK_HZ / 1000 * SECOND_MS;
   localparam int PPS_WIDTH_MS    = 100;
   localparam int PPS_WIDTH_CYC   = CLK_HZ / 1000 * PPS_WIDTH_MS;
   localparam int PPS_DELAY_S     = 3;
   localparam int STATUS_PERIOD_S = 1;
   localparam int DIV_W           = 12;
   localparam int DATA_BITS       = 8;
   localparam int FRAME_BITS      = 10;
   localparam int FIFO_DEPTH      = 8;
   localparam int STATUS_LEN      = 9;
   localparam int BKP_LEN         = 4;

   typedef enum logic [2:0] {
      RATE_4800, RATE_9600, RATE_19200, RATE_38400, RATE_57600, RATE_115200, RATE_230400
   } rate_t;
   localparam rate_t RATE_RESET = RATE_9600;
   localparam rate_t RATE_BKP   = RATE_9600;

   typedef enum logic [2:0] {
      MODE_BDS, MODE_GPS, MODE_GLO, MODE_BDS_GPS, MODE_GLO_BDS, MODE_GLO_GPS
   } mode_t;
   localparam mode_t MODE_RESET = MODE_BDS_GPS;

   typedef enum logic [1:0] {ANT_OK, ANT_OPEN, ANT_SHORT} ant_t;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } nmea_byte_t;

   localparam logic [7:0] CMD_SYNC    = 8'hb5;
   localparam logic [7:0] CMD_OP_RATE = 8'h01;
   localparam logic [7:0] CMD_OP_MODE = 8'h02;
   localparam logic [7:0] BKP_SYNC    = 8'ha5;

   function automatic logic [DIV_W-1:0] rate_div(input rate_t r);
      int baud;
      unique case (r)
         RATE_4800:   baud = 4800;
         RATE_9600:   baud = 9600;
         RATE_19200:  baud = 19200;
         RATE_38400:  baud = 38400;
         RATE_57600:  baud = 57600;
         RATE_115200: baud = 115200;
         RATE_230400: baud = 230400;
         default:     baud = 9600;
      endcase
      return DIV_W'(CLK_HZ / baud);
   endfunction : rate_div

   // status sentence: "$ANT,OK", "$ANT,OP" or "$ANT,SH" then cr lf
   function automatic logic [7:0] status_char(input ant_t a, input logic [3:0] idx);
      logic [15:0] code;
      code = (a == ANT_SHORT) ? 16'h5348 : (a == ANT_OPEN) ? 16'h4f50 : 16'h4f4b;
      case (idx)
         4'h0:    return 8'h24;
         4'h1:    return 8'h41;
         4'h2:    return 8'h4e;
         4'h3:    return 8'h54;
         4'h4:    return 8'h2c;
         4'h5:    return code[15:8];
         4'h6:    return code[7:0];
         4'h7:    return 8'h0d;
         default: return 8'h0a;
      endcase
   endfunction : status_char
endpackage : gnss_pkg

// ### hdl/byte_fifo.sv
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from pointers with one wrap bit
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
      end else if (in_valid && in_ready) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_ptr <= '0;
      end else if (out_valid && out_ready) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : byte_fifo

// ### hdl/serial_tx.sv
// Purpose: 8n1 serial transmitter
// Assumes: div is clock cycles per bit
// Notes:   divisor is latched per character
`timescale 1ns/1ps
module serial_tx (
   input  wire logic                       clk,
   input  wire logic                       nrst,
   input  wire logic [gnss_pkg::DIV_W-1:0] div,
   input  wire logic [7:0]                 in_data,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   output logic                            busy,
   output logic                            txd
);
   logic [gnss_pkg::DIV_W-1:0] char_div;
   logic [gnss_pkg::DIV_W-1:0] baud_cnt;
   logic [9:0]                 shift;
   logic [3:0]                 bits_left;

   assign busy     = bits_left != 4'h0;
   assign in_ready = !busy;
   assign txd      = shift[0];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift     <= '1;
         bits_left <= 4'h0;
         baud_cnt  <= '0;
         char_div  <= '0;
      end else if (in_valid && in_ready) begin
         shift     <= {1'b1, in_data, 1'b0};
         bits_left <= 4'(gnss_pkg::FRAME_BITS);
         char_div  <= div;
         baud_cnt  <= div - 1'b1;
      end else if (busy) begin
         if (baud_cnt == '0) begin
            baud_cnt  <= char_div - 1'b1;
            shift     <= {1'b1, shift[9:1]};
            bits_left <= bits_left - 4'h1;
         end else begin
            baud_cnt <= baud_cnt - 1'b1;
         end
      end
   end

   AST_START_BIT: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready |=> !txd && busy)
      else $error("start bit missing");
endmodule : serial_tx

// ### hdl/gnss_host_serial_port.sv
// Purpose: host serial port of a positioning receiver
// Assumes: 10 MHz clock, pins synchronous to it
// Notes:   command frame is sync byte, opcode, value
// Operation
// - characters are 8n1 both ways
// - rates 4800 to 230400 by command
// - 9600 after reset
// - sentence batch starts on second boundary
// - host commands set rate and mode
// - tx carries sentences and status only
// - antenna status sentence once per second
// - antenna status is ok, open or short
// - limit current on short, recover alone
// - low external reset pin resets device
// - pps silent until some seconds after fix
// - antenna enable drives high for on
// - backup port sends custom binary frame
// - six modes, dual first two at reset
`timescale 1ns/1ps
module gnss_host_serial_port #(
   parameter int SEC_CYCLES    = gnss_pkg::SEC_CYCLES,
   parameter int PPS_WIDTH_CYC = gnss_pkg::PPS_WIDTH_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 ext_reset_low,
   input  wire logic                 main_rxd,
   output logic                      main_txd,
   output logic                      backup_txd,
   input  wire gnss_pkg::nmea_byte_t nmea_in,
   input  wire logic                 nmea_valid,
   output logic                      nmea_ready,
   input  wire logic                 utc_sync,
   input  wire logic                 fix_valid,
   input  wire logic                 ant_open_det,
   input  wire logic                 ant_short_det,
   output logic                      antenna_lna_enable,
   output logic                      antenna_current_limit,
   output logic                      pulse_per_second_out,
   output gnss_pkg::mode_t           work_mode,
   output gnss_pkg::rate_t           baud_rate
);
   typedef enum {CMD_IDLE, CMD_OP, CMD_VAL} cmd_st_t;
   typedef enum {TX_WAIT, TX_BATCH, TX_STATUS} tx_st_t;

   logic                       rst_n;
   logic [gnss_pkg::DIV_W-1:0] div;
   logic [gnss_pkg::DIV_W-1:0] rx_cnt;
   logic [3:0]                 rx_idx;
   logic                       rx_active;
   logic                       rx_prev;
   logic [7:0]                 rx_shift;
   logic                       rx_strobe;
   cmd_st_t                    cmd_st;
   logic [7:0]                 cmd_op;
   gnss_pkg::rate_t            rate_pend;
   logic                       rate_pend_v;
   logic                       tx_busy;
   logic                       tx_ready;
   logic                       tx_valid;
   logic [7:0]                 tx_data;
   tx_st_t                     tx_st;
   logic [3:0]                 st_idx;
   logic                       status_due;
   gnss_pkg::nmea_byte_t       fifo_out;
   logic                       fifo_valid;
   logic                       fifo_ready;
   logic [23:0]                sec_cnt;
   logic                       sec_tick;
   logic [3:0]                 fix_secs;
   logic [19:0]                pps_cnt;
   gnss_pkg::ant_t             ant_state;
   logic [1:0]                 bkp_idx;
   logic                       bkp_ready;
   logic                       bkp_active;
   logic [7:0]                 bkp_data;

   //------------------------------------------------------------
   // reset and clocking
   //------------------------------------------------------------
   assign rst_n = nrst & ext_reset_low;
   assign div   = gnss_pkg::rate_div(baud_rate);

   // utc_sync realigns the second so batches start on the boundary
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt <= '0;
      end else if (utc_sync || sec_cnt == 24'(SEC_CYCLES - 1)) begin
         sec_cnt <= '0;
      end else begin
         sec_cnt <= sec_cnt + 24'h1;
      end
   end
   assign sec_tick = utc_sync || sec_cnt == 24'(SEC_CYCLES - 1);

   //------------------------------------------------------------
   // receiver, commands only
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_prev   <= 1'b1;
         rx_active <= 1'b0;
         rx_cnt    <= '0;
         rx_idx    <= 4'h0;
         rx_shift  <= 8'h00;
         rx_strobe <= 1'b0;
      end else begin
         rx_prev   <= main_rxd;
         rx_strobe <= 1'b0;
         if (!rx_active) begin
            if (rx_prev && !main_rxd) begin
               rx_active <= 1'b1;
               rx_cnt    <= div >> 1;
               rx_idx    <= 4'h0;
            end
         end else if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
         end else begin
            rx_cnt <= div - 1'b1;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == 4'h0 && main_rxd) begin
               rx_active <= 1'b0;
            end else if (rx_idx == 4'(gnss_pkg::DATA_BITS + 1)) begin
               rx_active <= 1'b0;
               rx_strobe <= main_rxd;
            end else if (rx_idx != 4'h0) begin
               rx_shift <= {main_rxd, rx_shift[7:1]};
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_st <= CMD_IDLE;
         cmd_op <= 8'h00;
      end else if (rx_strobe) begin
         unique case (cmd_st)
            CMD_IDLE: cmd_st <= (rx_shift == gnss_pkg::CMD_SYNC) ? CMD_OP : CMD_IDLE;
            CMD_OP: begin
               cmd_op <= rx_shift;
               cmd_st <= CMD_VAL;
            end
            CMD_VAL:  cmd_st <= CMD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_mode <= gnss_pkg::MODE_RESET;
      end else if (rx_strobe && cmd_st == CMD_VAL && cmd_op == gnss_pkg::CMD_OP_MODE
                   && rx_shift <= 8'(gnss_pkg::MODE_GLO_GPS)) begin
         work_mode <= gnss_pkg::mode_t'(rx_shift[2:0]);
      end
   end

   // a new rate waits until the transmitter is between characters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_rate   <= gnss_pkg::RATE_RESET;
         rate_pend   <= gnss_pkg::RATE_RESET;
         rate_pend_v <= 1'b0;
      end else if (rx_strobe && cmd_st == CMD_VAL && cmd_op == gnss_pkg::CMD_OP_RATE
                   && rx_shift <= 8'(gnss_pkg::RATE_230400)) begin
         rate_pend   <= gnss_pkg::rate_t'(rx_shift[2:0]);
         rate_pend_v <= 1'b1;
      end else if (rate_pend_v && !tx_busy && !tx_valid) begin
         baud_rate   <= rate_pend;
         rate_pend_v <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // main transmit: sentence batch then status
   //------------------------------------------------------------
   byte_fifo #(
      .WIDTH ($bits(gnss_pkg::nmea_byte_t)),
      .DEPTH (gnss_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (rst_n),
      .in_data   (nmea_in),
      .in_valid  (nmea_valid),
      .in_ready  (nmea_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st  <= TX_WAIT;
         st_idx <= 4'h0;
      end else begin
         unique case (tx_st)
            TX_WAIT: if (sec_tick) begin
               tx_st  <= fifo_valid ? TX_BATCH : TX_STATUS;
               st_idx <= 4'h0;
            end
            TX_BATCH: if (fifo_valid && fifo_ready && fifo_out.last) begin
               tx_st <= status_due ? TX_STATUS : TX_WAIT;
            end
            TX_STATUS: if (tx_valid && tx_ready) begin
               st_idx <= st_idx + 4'h1;
               if (st_idx == 4'(gnss_pkg::STATUS_LEN - 1)) begin
                  tx_st <= TX_WAIT;
               end
            end
         endcase
      end
   end

   // status_due marks seconds whose status sentence is still owed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_due <= 1'b0;
      end else if (tx_st == TX_WAIT && sec_tick) begin
         status_due <= 1'b1;
      end else if (tx_st == TX_STATUS) begin
         status_due <= 1'b0;
      end
   end

   // holding off while a rate change is pending keeps each character on one rate
   assign fifo_ready = tx_st == TX_BATCH && tx_ready && !rate_pend_v;
   assign tx_valid   = !rate_pend_v && ((tx_st == TX_BATCH && fifo_valid) || tx_st == TX_STATUS);
   assign tx_data    = (tx_st == TX_STATUS) ? gnss_pkg::status_char(ant_state, st_idx) : fifo_out.data;

   serial_tx u_main_tx (
      .clk      (clk),
      .nrst     (rst_n),
      .div      (div),
      .in_data  (tx_data),
      .in_valid (tx_valid),
      .in_ready (tx_ready),
      .busy     (tx_busy),
      .txd      (main_txd)
   );

   //------------------------------------------------------------
   // backup port, binary frame each second
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bkp_active <= 1'b0;
         bkp_idx    <= 2'h0;
      end else if (!bkp_active && sec_tick) begin
         bkp_active <= 1'b1;
         bkp_idx    <= 2'h0;
      end else if (bkp_active && bkp_ready) begin
         bkp_idx <= bkp_idx + 2'h1;
         if (bkp_idx == 2'(gnss_pkg::BKP_LEN - 1)) begin
            bkp_active <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (bkp_idx)
         2'h0: bkp_data = gnss_pkg::BKP_SYNC;
         2'h1: bkp_data = {5'h00, work_mode};
         2'h2: bkp_data = {6'h00, ant_state};
         2'h3: bkp_data = {7'h00, fix_valid};
      endcase
   end

   serial_tx u_bkp_tx (
      .clk      (clk),
      .nrst     (rst_n),
      .div      (gnss_pkg::rate_div(gnss_pkg::RATE_BKP)),
      .in_data  (bkp_data),
      .in_valid (bkp_active),
      .in_ready (bkp_ready),
      .busy     (),
      .txd      (backup_txd)
   );

   //------------------------------------------------------------
   // antenna and pps
   //------------------------------------------------------------
   // short wins over open: a short also looks like low impedance
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ant_state             <= gnss_pkg::ANT_OK;
         antenna_current_limit <= 1'b0;
         antenna_lna_enable    <= 1'b0;
      end else begin
         ant_state <= ant_short_det ? gnss_pkg::ANT_SHORT :
                      ant_open_det  ? gnss_pkg::ANT_OPEN : gnss_pkg::ANT_OK;
         antenna_current_limit <= ant_short_det;
         antenna_lna_enable    <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fix_secs <= 4'h0;
      end else if (!fix_valid) begin
         fix_secs <= 4'h0;
      end else if (sec_tick && fix_secs != 4'(gnss_pkg::PPS_DELAY_S)) begin
         fix_secs <= fix_secs + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pps_cnt              <= '0;
         pulse_per_second_out <= 1'b0;
      end else if (!fix_valid) begin
         pps_cnt              <= '0;
         pulse_per_second_out <= 1'b0;
      end else if (sec_tick && fix_secs == 4'(gnss_pkg::PPS_DELAY_S)) begin
         pps_cnt              <= 20'(PPS_WIDTH_CYC - 1);
         pulse_per_second_out <= 1'b1;
      end else if (pps_cnt != '0) begin
         pps_cnt <= pps_cnt - 20'h1;
      end else begin
         pulse_per_second_out <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   sequence mode_cmd_s;
      rx_strobe && cmd_st == CMD_VAL && cmd_op == gnss_pkg::CMD_OP_MODE && rx_shift < 8'h06;
   endsequence

   sequence rate_cmd_s;
      rx_strobe && cmd_st == CMD_VAL && cmd_op == gnss_pkg::CMD_OP_RATE && rx_shift < 8'h07;
   endsequence

   AST_MODE_CMD: assert property (@(posedge clk) disable iff (!rst_n)
      mode_cmd_s |=> work_mode == gnss_pkg::mode_t'($past(rx_shift[2:0])))
      else $error("mode command not applied");

   AST_RATE_CMD: assert property (@(posedge clk) disable iff (!rst_n)
      rate_cmd_s ##1 (!tx_busy && !tx_valid) |=> baud_rate == $past(rate_pend))
      else $error("rate command not applied");

   AST_RATE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(baud_rate) |-> $past(!tx_busy) && $past(rate_pend_v))
      else $error("rate changed mid character");

   AST_RATE_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> baud_rate == gnss_pkg::RATE_RESET && work_mode == gnss_pkg::MODE_RESET)
      else $error("rate or mode not at reset value");

   AST_BATCH_TICK: assert property (@(posedge clk) disable iff (!rst_n)
      tx_st != TX_WAIT && $past(tx_st) == TX_WAIT |-> $past(sec_tick))
      else $error("batch off the second boundary");

   AST_STATUS_LEN: assert property (@(posedge clk) disable iff (!rst_n)
      tx_st == TX_STATUS |-> st_idx < 4'h9)
      else $error("status sentence overrun");

   AST_ANT_STATE: assert property (@(posedge clk) disable iff (!rst_n)
      ant_short_det |=> ant_state == gnss_pkg::ANT_SHORT)
      else $error("antenna state wrong");

   AST_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
      !ant_short_det ##1 !ant_short_det |-> !antenna_current_limit)
      else $error("current limit stuck after short cleared");

   AST_PPS_FIX: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(pulse_per_second_out) |-> $past(fix_valid) && $past(fix_secs) == 4'h3)
      else $error("pps before fix delay");

   AST_LNA_ON: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> antenna_lna_enable)
      else $error("antenna enable low");

   AST_BKP_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(bkp_active) |-> bkp_idx == 2'h0 ##0 bkp_data == 8'ha5)
      else $error("backup frame lacks sync");
endmodule : gnss_host_serial_port

// ### bench/host_model.sv
// Purpose: host end of the serial link, sends commands and decodes lines
// Assumes: caller gives clock cycles per bit
// Notes:   rxd driven on falling edges, held high between characters
`timescale 1ns/1ps
module host_model (
   input  wire logic clk,
   input  wire logic main_txd,
   input  wire logic backup_txd,
   output logic      rxd
);
   // ------
   // tasks
   // ------
   initial rxd = 1'b1;

   // start, eight bits lsb first, stop; no parity
   task automatic send(input logic [7:0] b, input int div);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         rxd = f[i];
         repeat (div - 1) @(negedge clk);
      end
   endtask : send

   // mid-bit sampling; ok low flags a broken stop bit
   task automatic recv(input logic sel, input int div, output logic [7:0] b, output logic ok);
      logic ln;
      ln = 1'b1;
      while (ln) begin
         @(posedge clk);
         ln = sel ? backup_txd : main_txd;
      end
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge clk);
         b[i] = sel ? backup_txd : main_txd;
      end
      repeat (div) @(posedge clk);
      ok = sel ? backup_txd : main_txd;
   endtask : recv
endmodule : host_model

// ### bench/tb.sv
// Purpose: self-checking bench of the receiver host serial port
// Assumes: short second and pulse width keep the run brief
// Notes:   ticks forced by utc_sync, so spacing is under bench control
`timescale 1ns/1ps
module tb;
   // ------
   // setup
   // ------
   logic                 clk, nrst, ext_reset_low, rxd, main_txd, backup_txd, nmea_valid, nmea_ready;
   logic                 utc_sync, fix_valid, ant_open_det, ant_short_det, lna_en, ilim, pps;
   gnss_pkg::nmea_byte_t nmea_in;
   gnss_pkg::mode_t      work_mode;
   gnss_pkg::rate_t      baud_rate;
   int                   failures, total_checks, cycles, seed, n, div;
   logic [7:0]           exp_q[$];
   logic [71:0]          txt;

   gnss_host_serial_port #(.SEC_CYCLES(60000), .PPS_WIDTH_CYC(100)) uut (
      .clk(clk), .nrst(nrst), .ext_reset_low(ext_reset_low), .main_rxd(rxd), .main_txd(main_txd),
      .backup_txd(backup_txd), .nmea_in(nmea_in), .nmea_valid(nmea_valid), .nmea_ready(nmea_ready),
      .utc_sync(utc_sync), .fix_valid(fix_valid), .ant_open_det(ant_open_det), .ant_short_det(ant_short_det),
      .antenna_lna_enable(lna_en), .antenna_current_limit(ilim), .pulse_per_second_out(pps),
      .work_mode(work_mode), .baud_rate(baud_rate));
   host_model host (.clk(clk), .main_txd(main_txd), .backup_txd(backup_txd), .rxd(rxd));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %0h want %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic cmd(input logic [7:0] op, input logic [7:0] val);
      host.send(8'hb5, div);
      host.send(op, div);
      host.send(val, div);
      repeat (3) @(negedge clk);
   endtask : cmd

   task automatic tick;
      @(negedge clk);
      utc_sync = 1'b1;
      @(negedge clk);
      utc_sync = 1'b0;
   endtask : tick

   task automatic rx_cmp(input logic sel, input int d, input logic [7:0] q[$]);
      logic [7:0] v;
      logic       s;
      foreach (q[i]) begin
         host.recv(sel, d, v, s);
         chk({s, v}, {1'b1, q[i]});
      end
   endtask : rx_cmp

   // short outranks open, so both detectors high must read as short
   function automatic logic [71:0] status_text(input int k);
      logic [15:0] c;
      c = (k == 0) ? 16'h5348 : (k == 1) ? 16'h4f50 : 16'h4f4b;
      return {40'h24414e542c, c, 16'h0d0a};
   endfunction : status_text

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 120000) begin
         failures++;
         wrap_up();
      end
   end

   // ---------
   // sequence
   // ---------
   initial begin
      seed = 32'hf853181e;
      {nrst, ext_reset_low, nmea_valid, utc_sync, fix_valid, ant_open_det, ant_short_det} = 7'b0100000;
      nmea_in = '0;
      div = 1041;
      repeat (12) @(negedge clk);
      chk({main_txd, backup_txd, nmea_ready, lna_en, pps}, 5'b11100);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      chk({baud_rate, work_mode, lna_en}, {gnss_pkg::RATE_9600, gnss_pkg::MODE_BDS_GPS, 1'b1});
      cmd(8'h01, 8'h06);
      chk(baud_rate, gnss_pkg::RATE_230400);
      div = 43;
      cmd(8'h01, 8'h07);
      chk(baud_rate, gnss_pkg::RATE_230400);
      for (int m = 0; m < 7; m++) begin
         cmd(8'h02, 8'(m));
         chk(work_mode, (m < 6) ? m : 5);
      end
      fix_valid = 1'b1;
      n = 0;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         nmea_valid = 1'b1;
         nmea_in = {i == 7, 8'($random(seed))};
         #1;
         if (nmea_ready === 1'b1) begin
            exp_q.push_back(nmea_in.data);
            n++;
         end
      end
      @(negedge clk);
      nmea_valid = 1'b0;
      chk(n, 8);
      chk(main_txd, 1'b1);
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         {ant_open_det, ant_short_det} = (k == 0) ? 2'b11 : (k == 1) ? 2'b10 : 2'b00;
         repeat (2) @(negedge clk);
         chk({ilim, pps}, {k == 0, 1'b0});
         txt = status_text(k);
         for (int j = 8; j >= 0; j--) exp_q.push_back(txt[j*8 +: 8]);
         tick();
         fork
            rx_cmp(1'b0, 43, exp_q);
            if (k == 0) rx_cmp(1'b1, 1041, '{8'ha5, 8'h05, 8'h02, 8'h01});
         join
         exp_q.delete();
      end
      tick();
      n = 0;
      while (pps !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(pps, 1'b1);
      fix_valid = 1'b0;
      repeat (2) @(negedge clk);
      chk(pps, 1'b0);
      // status sentence still going out, so the new rate has to wait for a character end
      cmd(8'h01, 8'h05);
      repeat (500) @(negedge clk);
      chk(baud_rate, gnss_pkg::RATE_115200);
      ext_reset_low = 1'b0;
      #1;
      chk({baud_rate, work_mode, main_txd}, {gnss_pkg::RATE_9600, gnss_pkg::MODE_BDS_GPS, 1'b1});
      repeat (10010) @(negedge clk);
      ext_reset_low = 1'b1;
      repeat (2) @(negedge clk);
      chk(lna_en, 1'b1);
      wrap_up();
   end
endmodule : tb
